//--- design/lcdhi_defs.svh
// Constants of the LCD host port: timing, instruction fields, reset values and code ranges.
// Included by the host port top module lcdhi_top; holds definitions only.
`ifndef LCDHI_DEFS_SVH
`define LCDHI_DEFS_SVH

// ==========================================================================
// Timing
`define LCDHI_CLK_NS      8
`define LCDHI_EXEC_NS     72000
`define LCDHI_CLEAR_NS    1600000

// ==========================================================================
// Instruction fields
`define LCDHI_OP_CLEAR    8'h01
`define LCDHI_DL_BIT      4
`define LCDHI_RE_BIT      2
`define LCDHI_G_BIT       1
`define LCDHI_ID_BIT      1

// ==========================================================================
// Reset values of the mode flags
`define LCDHI_DL_RST      1'b1
`define LCDHI_RE_RST      1'b0
`define LCDHI_G_RST       1'b0
`define LCDHI_ID_RST      1'b1

// ==========================================================================
// Serial frame
`define LCDHI_SER_SYNC    5'h1f
`define LCDHI_SER_LAST    5'h17

// ==========================================================================
// Character code ranges
`define LCDHI_SPACE_CODE  8'h20
`define LCDHI_HALF_LO     8'h02
`define LCDHI_HALF_HI     8'h7f
`define LCDHI_FULL_LEAD   8'ha1
`define LCDHI_TRAD_LO     16'ha140
`define LCDHI_TRAD_HI     16'hd75f
`define LCDHI_SIMP_LO     16'ha1a0
`define LCDHI_SIMP_HI     16'hf7ff
`define LCDHI_TEXT_LAST   6'h3f

`endif

//--- design/lcdhi_pkg.sv
// Types shared by the LCD host port modules.
// Carries no constants; those sit in lcdhi_defs.svh.
package lcdhi_pkg;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       isel;
    logic       rs;
    logic       rw;
    logic       e;
    logic [7:0] db;
  } lcdhi_pins_t;

  typedef struct packed {
    logic       rs;
    logic [7:0] data;
  } lcdhi_acc_t;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {CORE_IDLE, CORE_CLEAR, CORE_BUSY} lcdhi_core_t;
  typedef enum logic [1:0] {MEM_TEXT, MEM_FONT, MEM_BITMAP} lcdhi_mem_t;
  typedef enum logic [1:0] {GLYPH_HALF, GLYPH_USER, GLYPH_FULL, GLYPH_BAD} lcdhi_glyph_t;

endpackage

//--- design/lcdhi_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; only the second stage may be read.
`timescale 1ns/10ps

module lcdhi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pins in, synchronised copy out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

//--- design/lcdhi_top.sv
// Host port and display memory addressing of a character and bitmap LCD controller.
// Assumes all host pins are asynchronous to clk; the bidirectional data bus is split
// into db_in, db_out and db_oe, and the bench resolves the wire.
`timescale 1ns/10ps
`include "lcdhi_defs.svh"

// Overview of operation
// - Interface-select high picks the parallel bus, low the clocked serial link.
// - Parallel transfers are 8-bit or 4-bit per bus-width bit; 4-bit uses DB7..DB4.
// - Register-select and read/write choose instruction, status, data write or data read.
// - The serial link only writes; nothing can be read over it.
// - Two 8-bit host registers: instruction register and data register to the RAMs.
// - While busy, busy indicator is 1 and instructions are ignored; 0 when done.
// - Each text or font word access steps the address pointer by one, direction set by entry mode.
// - Status read drives the address pointer onto DB6..DB0.
// - In serial mode register-select is chip select: high enables the receiver.
// - The external reset is active low and resets all registers but not the RAM contents.
// - A text word holds one full-width glyph or two half-width glyphs.
// - Text RAM has 64 two-byte words; only two character lines are shown.
// - Codes 0000, 0002, 0004, 0006 pick one of four user fonts.
// - Bytes 02 to 7F show a half-width glyph.
// - A byte from A1 upward joins the next byte into one full-width code.
// - Full-width codes lie in A140-D75F or A1A0-F7FF by font set.
// - Two-byte codes arrive upper byte first, lower byte second.
// - Full-width and user glyphs display only from the start of a word.
// - Bitmap address is two writes: vertical first, then horizontal of 16 bits.
// - After each bitmap word the horizontal address steps, wrapping 0F to 00.
// - Bus-width bit 1 selects 8-bit transfers, 0 selects 4-bit transfers.
// - A bitmap word is two bytes; the lower byte completes the word.
module lcdhi_top
  import lcdhi_pkg::*;
#(
  parameter int unsigned EXEC_CYC   = (`LCDHI_EXEC_NS + `LCDHI_CLK_NS - 1) / `LCDHI_CLK_NS,
  parameter int unsigned CLEAR_CYC  = (`LCDHI_CLEAR_NS + `LCDHI_CLK_NS - 1) / `LCDHI_CLK_NS,
  parameter bit          SIMPLIFIED = 1'b0
) (
  // Clock and active-low reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Host pins
  input  wire logic               interface_select,
  input  wire logic               register_select,
  input  wire logic               rw_serial_data_in,
  input  wire logic               enable_serial_clk,
  input  wire logic [7:0]         db_in,
  output logic      [7:0]         db_out,
  output logic                    db_oe,
  // Status
  output logic                    busy_indicator,
  output logic      [6:0]         address_pointer,
  output logic                    bus_width_bit,
  output logic                    graphic_on,
  // Display side read ports
  input  wire logic               glyph_row,
  input  wire logic [3:0]         glyph_col,
  output lcdhi_glyph_t            glyph_kind,
  output logic      [15:0]        glyph_code,
  output logic      [1:0]         glyph_half_ok,
  input  wire logic [9:0]         bitmap_rd_addr,
  output logic      [15:0]        bitmap_rd_data
);

  // ==========================================================================
  // Pin synchronisation and strobe edges
  lcdhi_pins_t  pins_raw;
  lcdhi_pins_t  pins_s;
  logic         e_prev_reg;
  logic         e_rise;
  logic         e_fall;

  assign pins_raw = '{isel: interface_select, rs: register_select, rw: rw_serial_data_in,
                      e: enable_serial_clk, db: db_in};

  lcdhi_sync #(.WIDTH($bits(lcdhi_pins_t))) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins_s)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e_prev_reg <= 1'b0;
    end else begin
      e_prev_reg <= pins_s.e;
    end
  end

  assign e_rise = pins_s.e & ~e_prev_reg;
  assign e_fall = ~pins_s.e & e_prev_reg;

  // ==========================================================================
  // Mode state
  lcdhi_core_t  state_reg;
  lcdhi_mem_t   mem_reg;
  logic         dl_reg;
  logic         re_reg;
  logic         g_reg;
  logic         id_reg;
  logic [5:0]   ac_reg;
  logic [5:0]   gd_v_reg;
  logic [3:0]   gd_h_reg;
  logic         gd_second_reg;
  logic         upper_next_reg;
  logic [7:0]   upper_byte_reg;
  logic [23:0]  timer_reg;
  logic [5:0]   fill_reg;
  logic         busy_now;

  assign busy_now = (state_reg != CORE_IDLE);

  // ==========================================================================
  // Parallel receiver
  // The byte is taken on the falling strobe, when the host data is known to be settled.
  logic         nib_hi_reg;
  logic [3:0]   nib_buf_reg;
  logic         par_strobe;
  logic         byte_done;

  assign par_strobe = pins_s.isel & e_fall;
  assign byte_done  = par_strobe & (dl_reg | ~nib_hi_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nib_hi_reg  <= 1'b1;
      nib_buf_reg <= 4'h0;
    end else if (dl_reg) begin
      nib_hi_reg  <= 1'b1;
    end else if (par_strobe) begin
      nib_hi_reg <= ~nib_hi_reg;
      if (nib_hi_reg) begin
        nib_buf_reg <= pins_s.db[7:4];
      end
    end
  end

  // ==========================================================================
  // Serial receiver
  // Frame: five ones, RW, RS, zero, then upper and lower nibble each followed by four zeros.
  logic [22:0]  sh_reg;
  logic [4:0]   sbit_cnt_reg;
  logic         ser_on;
  logic         ser_done;
  logic [23:0]  ser_frame;

  assign ser_on    = ~pins_s.isel & pins_s.rs;
  assign ser_frame = {sh_reg, pins_s.rw};
  assign ser_done  = ser_on & e_rise & (sbit_cnt_reg == `LCDHI_SER_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg       <= 23'h0;
      sbit_cnt_reg <= 5'h0;
    end else if (!ser_on) begin
      sbit_cnt_reg <= 5'h0;
    end else if (e_rise) begin
      sh_reg       <= ser_frame[22:0];
      sbit_cnt_reg <= ser_done ? 5'h0 : sbit_cnt_reg + 5'h1;
    end
  end

  // ==========================================================================
  // Access merge and instruction decode
  lcdhi_acc_t   acc;
  logic         acc_v;
  logic         rd_done;
  logic         ins_go;
  logic         dat_go;
  logic         op_clear;
  logic         op_home;
  logic         op_entry;
  logic         op_fset;
  logic         op_font;
  logic         op_text;
  logic         op_gd;
  logic         word_wr;
  logic         word_rd;

  always_comb begin
    acc     = '0;
    acc_v   = 1'b0;
    rd_done = 1'b0;
    if (pins_s.isel) begin
      acc.rs   = pins_s.rs;
      acc.data = dl_reg ? pins_s.db : {nib_buf_reg, pins_s.db[7:4]};
      acc_v    = byte_done & ~pins_s.rw;
      rd_done  = byte_done & pins_s.rw & pins_s.rs;
    end else begin
      acc.rs   = ser_frame[17];
      acc.data = {ser_frame[15:12], ser_frame[7:4]};
      acc_v    = ser_done & (ser_frame[23:19] == `LCDHI_SER_SYNC) & ~ser_frame[18];
    end
  end

  assign ins_go   = acc_v & ~acc.rs & ~busy_now;
  assign dat_go   = acc_v & acc.rs;
  assign op_clear = ins_go & ~re_reg & (acc.data == `LCDHI_OP_CLEAR);
  assign op_home  = ins_go & ~re_reg & (acc.data[7:1] == 7'h01);
  assign op_entry = ins_go & ~re_reg & (acc.data[7:2] == 6'h01);
  assign op_fset  = ins_go & (acc.data[7:5] == 3'h1);
  assign op_font  = ins_go & ~re_reg & (acc.data[7:6] == 2'h1);
  assign op_text  = ins_go & ~re_reg & acc.data[7];
  assign op_gd    = ins_go & re_reg & acc.data[7];
  assign word_wr  = dat_go & ~upper_next_reg;
  assign word_rd  = rd_done & ~upper_next_reg;

  // ==========================================================================
  // Mode flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dl_reg  <= `LCDHI_DL_RST;
      re_reg  <= `LCDHI_RE_RST;
      g_reg   <= `LCDHI_G_RST;
      id_reg  <= `LCDHI_ID_RST;
      mem_reg <= MEM_TEXT;
    end else begin
      if (op_fset) begin
        dl_reg <= acc.data[`LCDHI_DL_BIT];
        re_reg <= acc.data[`LCDHI_RE_BIT];
        if (acc.data[`LCDHI_RE_BIT]) begin
          g_reg <= acc.data[`LCDHI_G_BIT];
        end
      end
      if (op_clear) begin
        id_reg <= 1'b1;
      end else if (op_entry) begin
        id_reg <= acc.data[`LCDHI_ID_BIT];
      end
      if (op_clear || op_home || op_text) begin
        mem_reg <= MEM_TEXT;
      end else if (op_font) begin
        mem_reg <= MEM_FONT;
      end else if (op_gd && gd_second_reg) begin
        mem_reg <= MEM_BITMAP;
      end
    end
  end

  // ==========================================================================
  // Address pointer and byte pairing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_reg        <= 6'h0;
      gd_v_reg      <= 6'h0;
      gd_h_reg      <= 4'h0;
      gd_second_reg <= 1'b0;
    end else begin
      if (op_clear || op_home) begin
        ac_reg <= 6'h0;
      end else if (op_font || op_text) begin
        ac_reg <= acc.data[5:0];
      end else if (op_gd && !gd_second_reg) begin
        gd_v_reg <= acc.data[5:0];
        ac_reg   <= acc.data[5:0];
      end else if (op_gd) begin
        gd_h_reg <= acc.data[3:0];
        ac_reg   <= {2'h0, acc.data[3:0]};
      end else if ((word_wr || word_rd) && mem_reg == MEM_BITMAP) begin
        gd_h_reg <= gd_h_reg + 4'h1;
        ac_reg   <= {2'h0, 4'(gd_h_reg + 4'h1)};
      end else if (word_wr || word_rd) begin
        ac_reg <= id_reg ? ac_reg + 6'h1 : ac_reg - 6'h1;
      end
      if (op_gd) begin
        gd_second_reg <= ~gd_second_reg;
      end else if (ins_go) begin
        gd_second_reg <= 1'b0;
      end
    end
  end

  // An address-setting instruction realigns pairing so the next byte is an upper byte.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_next_reg <= 1'b1;
      upper_byte_reg <= 8'h0;
    end else begin
      if (op_clear || op_home || op_font || op_text || op_gd) begin
        upper_next_reg <= 1'b1;
      end else if (dat_go || rd_done) begin
        upper_next_reg <= ~upper_next_reg;
      end
      if (dat_go && upper_next_reg) begin
        upper_byte_reg <= acc.data;
      end
    end
  end

  // ==========================================================================
  // Busy sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CORE_IDLE;
      timer_reg <= 24'h0;
      fill_reg  <= 6'h0;
    end else begin
      case (state_reg)
        CORE_IDLE: begin
          if (op_clear) begin
            state_reg <= CORE_CLEAR;
            timer_reg <= 24'(CLEAR_CYC - 1);
            fill_reg  <= 6'h0;
          end else if (ins_go) begin
            state_reg <= CORE_BUSY;
            timer_reg <= 24'(EXEC_CYC - 1);
          end
        end
        CORE_CLEAR: begin
          timer_reg <= (timer_reg == 24'h0) ? 24'h0 : timer_reg - 24'h1;
          fill_reg  <= fill_reg + 6'h1;
          if (fill_reg == `LCDHI_TEXT_LAST) begin
            state_reg <= CORE_BUSY;
          end
        end
        CORE_BUSY: begin
          if (timer_reg == 24'h0) begin
            state_reg <= CORE_IDLE;
          end else begin
            timer_reg <= timer_reg - 24'h1;
          end
        end
        default: begin
          state_reg <= CORE_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Memories
  // Clearing has priority over a data write; a host that writes while busy breaks protocol.
  logic [15:0]  text_ram   [64];
  logic [15:0]  font_ram   [64];
  logic [15:0]  bitmap_ram [1024];
  logic [15:0]  new_word;

  assign new_word = {upper_byte_reg, acc.data};

  always_ff @(posedge clk) begin
    if (state_reg == CORE_CLEAR) begin
      text_ram[fill_reg] <= {2{`LCDHI_SPACE_CODE}};
    end else if (word_wr && mem_reg == MEM_TEXT) begin
      text_ram[ac_reg] <= new_word;
    end
    if (word_wr && mem_reg == MEM_FONT) begin
      font_ram[ac_reg] <= new_word;
    end
    if (word_wr && mem_reg == MEM_BITMAP) begin
      bitmap_ram[{gd_v_reg, gd_h_reg}] <= new_word;
    end
  end

  // ==========================================================================
  // Read path and pin outputs
  logic [15:0]  rd_word;
  logic [7:0]   rd_byte;

  always_comb begin
    case (mem_reg)
      MEM_FONT:   rd_word = font_ram[ac_reg];
      MEM_BITMAP: rd_word = bitmap_ram[{gd_v_reg, gd_h_reg}];
      default:    rd_word = text_ram[ac_reg];
    endcase
    if (pins_s.rs) begin
      rd_byte = upper_next_reg ? rd_word[15:8] : rd_word[7:0];
    end else begin
      rd_byte = {busy_now, 1'b0, ac_reg};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      db_oe           <= 1'b0;
      db_out          <= 8'h0;
      busy_indicator  <= 1'b0;
      address_pointer <= 7'h0;
      bus_width_bit   <= `LCDHI_DL_RST;
      graphic_on      <= `LCDHI_G_RST;
    end else begin
      db_oe           <= pins_s.isel & pins_s.rw & pins_s.e;
      db_out          <= dl_reg ? rd_byte : {(nib_hi_reg ? rd_byte[7:4] : rd_byte[3:0]), 4'h0};
      busy_indicator  <= busy_now;
      address_pointer <= {1'b0, ac_reg};
      bus_width_bit   <= dl_reg;
      graphic_on      <= g_reg;
    end
  end

  // ==========================================================================
  // Glyph decode for the display scan
  // Only two character lines are scanned; the other two stay stored but unseen.
  logic [15:0]  scan_word;
  lcdhi_glyph_t kind_next;
  logic [1:0]   half_next;
  logic         in_full;

  assign scan_word = text_ram[{1'b0, glyph_row, glyph_col}];
  assign in_full   = SIMPLIFIED ?
                     (scan_word >= `LCDHI_SIMP_LO && scan_word <= `LCDHI_SIMP_HI) :
                     (scan_word >= `LCDHI_TRAD_LO && scan_word <= `LCDHI_TRAD_HI);

  always_comb begin
    kind_next = GLYPH_BAD;
    half_next = 2'b00;
    if (scan_word[15:3] == 13'h0 && !scan_word[0]) begin
      kind_next = GLYPH_USER;
    end else if (scan_word[15:8] >= `LCDHI_FULL_LEAD) begin
      kind_next = in_full ? GLYPH_FULL : GLYPH_BAD;
    end else begin
      kind_next = GLYPH_HALF;
      half_next[1] = scan_word[15:8] >= `LCDHI_HALF_LO && scan_word[15:8] <= `LCDHI_HALF_HI;
      half_next[0] = scan_word[7:0] >= `LCDHI_HALF_LO && scan_word[7:0] <= `LCDHI_HALF_HI;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      glyph_kind     <= GLYPH_BAD;
      glyph_code     <= 16'h0;
      glyph_half_ok  <= 2'b00;
      bitmap_rd_data <= 16'h0;
    end else begin
      glyph_kind     <= kind_next;
      glyph_code     <= scan_word;
      glyph_half_ok  <= half_next;
      bitmap_rd_data <= bitmap_ram[bitmap_rd_addr];
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_serial_no_read: assert property (!pins_s.isel |=> !db_oe)
    else $error("data bus driven in serial mode");
  chk_status_read: assert property ((pins_s.isel && pins_s.rw && pins_s.e && !pins_s.rs && dl_reg)
    |=> (db_out[6:0] == address_pointer && db_out[7] == busy_indicator))
    else $error("status read does not show pointer and busy");
  chk_busy_set: assert property (ins_go |-> ##2 busy_indicator)
    else $error("accepted instruction did not raise busy");
  chk_busy_ignore: assert property ((acc_v && !acc.rs && busy_now)
    |=> ($stable(ac_reg) && $stable(dl_reg) && $stable(id_reg)))
    else $error("instruction acted on while busy");
  chk_ptr_step: assert property ((word_wr && mem_reg != MEM_BITMAP)
    |=> ac_reg == ($past(id_reg) ? 6'($past(ac_reg) + 6'h1) : 6'($past(ac_reg) - 6'h1)))
    else $error("address pointer did not step by one");
  chk_gd_wrap: assert property ((word_wr && mem_reg == MEM_BITMAP)
    |=> (gd_h_reg == 4'($past(gd_h_reg) + 4'h1) && $stable(gd_v_reg)))
    else $error("bitmap horizontal step wrong");
  chk_gd_order: assert property ((op_gd && !gd_second_reg)
    |=> (gd_second_reg && gd_v_reg == $past(acc.data[5:0])))
    else $error("vertical bitmap address not taken first");
  chk_cs_off: assert property ((!pins_s.isel && !pins_s.rs) |=> sbit_cnt_reg == 5'h0)
    else $error("serial receiver counting with chip select low");
  chk_width_set: assert property (op_fset |=> ##1 bus_width_bit == $past(acc.data[`LCDHI_DL_BIT], 2))
    else $error("bus width bit not taken from function set");
  chk_nibble_pair: assert property ((par_strobe && !dl_reg && nib_hi_reg && !pins_s.rw) |-> !acc_v)
    else $error("upper nibble completed a byte");

  cov_serial_ins: cover property (ins_go && !pins_s.isel);
  cov_bitmap_word: cover property (word_wr && mem_reg == MEM_BITMAP);
  cov_nibble_byte: cover property (acc_v && !dl_reg && pins_s.isel);
  cov_glyph_full: cover property (kind_next == GLYPH_FULL);

endmodule

//--- verif/lcdhi_host.sv
// Host processor model for the LCD host port: parallel strobes and serial frames.
// Assumes a free-running clk; the bench resolves the data bus from db_oe.
`timescale 1ns/10ps
module lcdhi_host import lcdhi_pkg::*; (
  // Clock and read data
  input  wire logic [0:0] clk,
  input  wire logic [7:0] db_out,
  // Host pins
  output lcdhi_pins_t     pin
);
  logic four = 1'b0;
  initial pin = 12'h800;
  // ==========
  // Parallel strobe. Every phase outlasts the port's 3-cycle sync and edge path.
  task automatic stb(input logic r, w, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    {pin.rs, pin.rw, pin.db} = {r, w, w ? ~d : d};
    repeat (4) @(negedge clk);
    pin.e = 1'b1;
    repeat (6) @(negedge clk);
    q = db_out;
    pin.e = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  task automatic acc(input logic r, w, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] lo;
    if (!four) stb(r, w, d, q);
    else begin
      stb(r, w, {d[7:4], 4'h0}, q);
      stb(r, w, {d[3:0], 4'h0}, lo);
      q = {q[7:4], lo[7:4]};
    end
  endtask
  // ==========
  // Serial frame on a 125 ns link clock. The link clock stands still between frames.
  task automatic ser(input logic r, input logic [7:0] d);
    logic [23:0] f;
    f = {5'h1f, 1'b0, r, 1'b0, d[7:4], 4'h0, d[3:0], 4'h0};
    {pin.isel, pin.rs} = 2'b01;
    #100;
    for (int i = 23; i >= 0; i--) begin
      pin.rw = f[i];
      #31 pin.e = 1'b1;
      #62 pin.e = 1'b0;
      #32;
    end
    pin.rs = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench of the LCD host port: parallel, 4-bit, serial, text and bitmap paths.
// Assumes lcdhi_host drives the pins and the port treats them as asynchronous.
`timescale 1ns/10ps
`define CHK(n, x, a) begin samples_checked++; if ((a) !== (x)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, x, a); end end
module tb import lcdhi_pkg::*;;
  logic         clk = 1'b0, rst_n = 1'b0, grow = 1'b0;
  logic         oe, busy, bw, gon;
  logic [3:0]   gcol = 4'h0;
  logic [9:0]   baddr = 10'h000;
  logic [7:0]   dout, q;
  logic [6:0]   ap;
  logic [1:0]   ghalf;
  logic [15:0]  gcode, bdata, ws [10];
  logic [31:0]  r, seed = 32'hb24b8001;
  lcdhi_glyph_t gkind;
  lcdhi_pins_t  p;
  int           miscompares = 0, samples_checked = 0;
  always #4 clk = ~clk;
  // A released bus reads back inverted, so a missing output enable shows up as a mismatch.
  lcdhi_host h (.clk(clk), .db_out(oe ? dout : ~dout), .pin(p));
  always @(negedge clk) if (oe) `CHK("oe", 1'b1, p.isel & p.rw)
  lcdhi_top #(.EXEC_CYC(20), .CLEAR_CYC(100)) uut (.clk(clk), .rst_n(rst_n), .interface_select(p.isel),
    .register_select(p.rs), .rw_serial_data_in(p.rw), .enable_serial_clk(p.e), .db_in(oe ? dout : p.db),
    .db_out(dout), .db_oe(oe), .busy_indicator(busy), .address_pointer(ap), .bus_width_bit(bw),
    .graphic_on(gon), .glyph_row(grow), .glyph_col(gcol), .glyph_kind(gkind), .glyph_code(gcode),
    .glyph_half_ok(ghalf), .bitmap_rd_addr(baddr), .bitmap_rd_data(bdata));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic lcdhi_glyph_t kind(input logic [15:0] x);
    if (x[15:3] == 13'h0 && !x[0]) return GLYPH_USER;
    if (x[15:8] < 8'ha1) return GLYPH_HALF;
    return (x >= 16'ha140 && x <= 16'hd75f) ? GLYPH_FULL : GLYPH_BAD;
  endfunction
  // ==========
  // Bus helpers
  task automatic waitb();
    for (int n = 0; n < 300 && busy !== 1'b0; n++) @(negedge clk);
    `CHK("idle", 1'b0, busy)
  endtask
  task automatic ins(input logic [7:0] d);
    h.acc(1'b0, 1'b0, d, q);
    @(negedge clk);
    `CHK("busy", 1'b1, busy)
    waitb();
  endtask
  task automatic wd(input logic [15:0] x);
    h.acc(1'b1, 1'b0, x[15:8], q);
    h.acc(1'b1, 1'b0, x[7:0], q);
  endtask
  task automatic gchk(input logic [4:0] i, input logic [15:0] x);
    {grow, gcol} = i;
    repeat (2) @(negedge clk);
    `CHK("code", x, gcode)
    `CHK("kind", kind(x), gkind)
  endtask
  task automatic test_done();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  // ==========
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    `CHK("ap", 7'h00, ap)
    `CHK("bw", 1'b1, bw)
    h.acc(1'b0, 1'b0, 8'h85, q);
    h.acc(1'b0, 1'b0, 8'h89, q);
    waitb();
    h.acc(1'b0, 1'b1, 8'h00, q);
    `CHK("status", 8'h05, q)
    ws = '{16'h0004, 16'h0006, 16'h4142, 16'ha140, 16'hd75f, 16'hd760, 16'h0, 16'h0, 16'h0, 16'h0};
    for (int i = 6; i < 10; i++) begin
      r = xs();
      ws[i] = r[0] ? 16'ha140 + r[15:2] : {2'b01, r[13:8], 2'b01, r[5:0]};
    end
    foreach (ws[i]) wd(ws[i]);
    `CHK("ap", 7'h0f, ap)
    foreach (ws[i]) gchk(5'(i + 5), ws[i]);
    gchk(5'd7, 16'h4142);
    `CHK("half", 2'b11, ghalf)
    ins(8'h05);
    ins(8'h87);
    h.acc(1'b1, 1'b1, 8'h00, q);
    `CHK("rd_hi", 8'h41, q)
    h.acc(1'b1, 1'b1, 8'h00, q);
    `CHK("rd_lo", 8'h42, q)
    `CHK("ap_dn", 7'h06, ap)
    ins(8'h01);
    `CHK("clr_ap", 7'h00, ap)
    gchk(5'd7, 16'h2020);
    ins(8'h20);
    `CHK("bw", 1'b0, bw)
    h.four = 1'b1;
    ins(8'h94);
    wd(16'h5a3c);
    gchk(5'd20, 16'h5a3c);
    ins(8'h30);
    h.four = 1'b0;
    h.ser(1'b0, 8'h9e);
    waitb();
    h.ser(1'b1, 8'h33);
    h.ser(1'b1, 8'h44);
    h.pin.isel = 1'b1;
    gchk(5'd30, 16'h3344);
    ins(8'h36);
    `CHK("gon", 1'b1, gon)
    ins(8'h87);
    ins(8'h8f);
    r = xs();
    wd(r[31:16]);
    wd(r[15:0]);
    baddr = 10'h07f;
    repeat (2) @(negedge clk);
    `CHK("bmp", r[31:16], bdata)
    baddr = 10'h070;
    repeat (2) @(negedge clk);
    `CHK("wrap", r[15:0], bdata)
    rst_n = 1'b0;
    @(negedge clk);
    `CHK("rst_gon", 1'b0, gon)
    `CHK("rst_ap", 7'h00, ap)
    rst_n = 1'b1;
    test_done();
  end
endmodule
